// [verif/watchdog_timer_with_trap_select_bench.sv]
`timescale 1ns/1ps
module watchdog_timer_with_trap_select_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fast_tick = 1'b0;
    logic        slow_tick = 1'b0;
    logic        slow_mode = 1'b0;
    logic        divider_tap_select = 1'b1;
    logic        low_power_hold = 1'b0;
    logic        interrupt_master_flag = 1'b0;
    logic        tick_on = 1'b0;
    logic        wdt_reset_request;
    logic        watchdog_interrupt_request;
    logic        trap_area_select;
    logic        trap_action_select;
    logic        watchdog_active;
    int          nmi_depth;
    int          resets_seen;
    logic        long_pulse;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic        er;
    int          cyc;
    logic        r;
    logic        i;

    wdt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_tick(fast_tick), .slow_tick(slow_tick), .slow_mode(slow_mode),
        .divider_tap_select(divider_tap_select), .low_power_hold(low_power_hold),
        .wdt_reset_request(wdt_reset_request), .watchdog_interrupt_request(watchdog_interrupt_request),
        .trap_area_select(trap_area_select), .trap_action_select(trap_action_select),
        .watchdog_active(watchdog_active));

    wdt_core_model core (.pclk(pclk), .presetn(presetn), .wdt_reset_request(wdt_reset_request),
        .watchdog_interrupt_request(watchdog_interrupt_request),
        .interrupt_master_flag(interrupt_master_flag), .nmi_depth(nmi_depth),
        .resets_seen(resets_seen), .long_pulse(long_pulse));

    // ---------------------------------------------------------------
    // Clock, source ticks and the hang limit.
    // ---------------------------------------------------------------
    always #12.5 pclk = ~pclk;

    // Ticks every cycle keep the shortest periods short.
    always @(posedge pclk) begin
        slow_tick <= tick_on;
        fast_tick <= tick_on;
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            complete_run();
        end
    end

    // ---------------------------------------------------------------
    // Shared tasks.
    // ---------------------------------------------------------------
    task automatic complete_run();
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; waits for pready, then releases the request.
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset();
        tick_on <= 1'b0;
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // Counts cycles until either request pulse or the limit.
    task automatic wait_ovf(input int lim);
        cyc = 0;
        r = 1'b0;
        i = 1'b0;
        while (cyc < lim && !r && !i) begin
            @(posedge pclk);
            cyc++;
            r = (wdt_reset_request === 1'b1);
            i = (watchdog_interrupt_request === 1'b1);
        end
    endtask

    task automatic in_window(input int lo, input int hi);
        check("overflow_window", 32'h1, {31'h0, (cyc >= lo && cyc <= hi)});
    endtask

    task automatic cmd(input logic [7:0] code);
        apb(wdt_pkg::COMMAND_INDEX, 1'b1, {24'h0, code});
    endtask

    // ---------------------------------------------------------------
    // Scenarios.
    // ---------------------------------------------------------------
    task automatic scn_reset_state();
        check("active", 32'h1, {31'h0, watchdog_active});
        check("trap_area", 32'h1, {31'h0, trap_area_select});
        check("trap_action", 32'h1, {31'h0, trap_action_select});
        apb(wdt_pkg::STATUS_INDEX, 1'b0, 32'h0);
        check("status", 32'h13, rd);
        apb(wdt_pkg::CONTROL_INDEX, 1'b0, 32'h0);
        check("control_read", 32'h0, rd);
        apb(8'h37, 1'b0, 32'h0);
        check("unmapped_err", 32'h1, {31'h0, er});
    endtask

    task automatic scn_reset_overflow();
        apb(wdt_pkg::CONTROL_INDEX, 1'b1, 32'h3f);
        tick_on <= 1'b1;
        cmd(wdt_pkg::CMD_CLEAR);
        repeat (4) begin
            wait_ovf(1200);
            check("no_req", 32'h0, {30'h0, r, i});
            cmd(wdt_pkg::CMD_CLEAR);
        end
        cmd(8'h00);
        cmd(8'h4f);
        cmd(8'hff);
        wait_ovf(2200);
        check("reset_req", 32'h2, {30'h0, r, i});
        // Credit the nine cycles the three ignored codes took after the clear.
        cyc = cyc + 9;
        in_window(3 * 512 - 5, 4 * 512 + 20);
        repeat (2) @(posedge pclk);
        check("resets_seen", 32'h1, resets_seen);
    endtask

    task automatic scn_interrupt();
        do_reset();
        apb(wdt_pkg::CONTROL_INDEX, 1'b1, 32'h3e);
        apb(wdt_pkg::CONTROL_INDEX, 1'b1, 32'h3f);
        apb(wdt_pkg::STATUS_INDEX, 1'b0, 32'h0);
        check("action_stuck", 32'h11, rd);
        tick_on <= 1'b1;
        cmd(wdt_pkg::CMD_CLEAR);
        wait_ovf(2200);
        check("int_req", 32'h1, {30'h0, r, i});
        wait_ovf(2200);
        check("int_again", 32'h1, {30'h0, r, i});
        in_window(2040, 2056);
        repeat (2) @(posedge pclk);
        check("nmi_depth", 32'h2, nmi_depth);
    endtask

    task automatic scn_disable();
        cmd(wdt_pkg::CMD_CLEAR);
        cmd(wdt_pkg::CMD_DISABLE);
        @(posedge pclk);
        check("still_on", 32'h1, {31'h0, watchdog_active});
        apb(wdt_pkg::CONTROL_INDEX, 1'b1, 32'h36);
        @(posedge pclk);
        check("on_no_code", 32'h1, {31'h0, watchdog_active});
        cmd(wdt_pkg::CMD_DISABLE);
        @(posedge pclk);
        check("off", 32'h0, {31'h0, watchdog_active});
        wait_ovf(3000);
        check("off_no_req", 32'h0, {30'h0, r, i});
        apb(wdt_pkg::STATUS_INDEX, 1'b0, 32'h0);
        check("off_status", 32'h10, rd);
        apb(wdt_pkg::CONTROL_INDEX, 1'b1, 32'h3e);
    endtask

    task automatic scn_hold();
        cmd(wdt_pkg::CMD_CLEAR);
        repeat (1000) @(posedge pclk);
        low_power_hold <= 1'b1;
        wait_ovf(5000);
        check("held_no_req", 32'h0, {30'h0, r, i});
        apb(wdt_pkg::STATUS_INDEX, 1'b0, 32'h0);
        check("hold_bit", 32'h1, {31'h0, rd[5]});
        low_power_hold <= 1'b0;
        wait_ovf(4000);
        check("resume_req", 32'h1, {30'h0, r, i});
        cyc = cyc + 1000;
        in_window(3 * 512 - 5, 4 * 512 + 20);
    endtask

    task automatic scn_trap();
        apb(wdt_pkg::CONTROL_INDEX, 1'b1, 32'h0f);
        @(posedge pclk);
        check("trap_action", 32'h0, {31'h0, trap_action_select});
        check("area_waits", 32'h1, {31'h0, trap_area_select});
        cmd(wdt_pkg::CMD_ARM_TRAP);
        @(posedge pclk);
        check("area_armed", 32'h0, {31'h0, trap_area_select});
    endtask

    task automatic scn_slow_mode();
        do_reset();
        slow_mode <= 1'b1;
        divider_tap_select <= 1'b0;
        apb(wdt_pkg::CONTROL_INDEX, 1'b1, 32'h3d);
        tick_on <= 1'b1;
        cmd(wdt_pkg::CMD_CLEAR);
        wait_ovf(9000);
        check("slow_reset", 32'h2, {30'h0, r, i});
        in_window(3 * 2048 - 5, 4 * 2048 + 20);
        check("single_pulse", 32'h0, {31'h0, long_pulse});
        // Fast taps with the shortest code must not overflow where slow taps would.
        slow_mode <= 1'b0;
        divider_tap_select <= 1'b0;
        apb(wdt_pkg::CONTROL_INDEX, 1'b1, 32'h3f);
        cmd(wdt_pkg::CMD_CLEAR);
        wait_ovf(3000);
        check("fast_taps_long", 32'h0, {30'h0, r, i});
    endtask

    // Main sequence.
    initial begin
        do_reset();
        scn_reset_state();
        scn_reset_overflow();
        scn_interrupt();
        scn_disable();
        scn_hold();
        scn_trap();
        check("single_pulse", 32'h0, {31'h0, long_pulse});
        scn_slow_mode();
        complete_run();
    end
endmodule

// [verif/wdt_core_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Core model that takes the watchdog's reset and NMI requests.
// ---------------------------------------------------------------
module wdt_core_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic wdt_reset_request,
    input  wire logic watchdog_interrupt_request,
    input  wire logic interrupt_master_flag,
    output int        nmi_depth,
    output int        resets_seen,
    output logic      long_pulse
);
    logic last_rst;
    logic last_nmi;

    // Every NMI nests at once; the master flag gates nothing here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_depth   <= 0;
            resets_seen <= 0;
            long_pulse  <= 1'b0;
            last_rst    <= 1'b0;
            last_nmi    <= 1'b0;
        end else begin
            last_rst <= wdt_reset_request;
            last_nmi <= watchdog_interrupt_request;
            if (watchdog_interrupt_request) begin
                nmi_depth <= nmi_depth + 1;
            end
            if (wdt_reset_request && !last_rst) begin
                resets_seen <= resets_seen + 1;
            end
            long_pulse <= long_pulse | (wdt_reset_request & last_rst)
                          | (watchdog_interrupt_request & last_nmi);
        end
    end
endmodule

// [verilog/wdt_binary_counter.sv]
`timescale 1ns/1ps
module wdt_binary_counter #(
    parameter int WIDTH = wdt_pkg::BIN_WIDTH
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             step,
    input  wire logic             clear,
    output logic [WIDTH-1:0]      count,
    output logic                  overflow
);

    // -----------------------------------------------------------------
    // Elaboration check.
    // -----------------------------------------------------------------
    if (WIDTH < 1) begin : g_width_check
        $error("Binary counter needs at least one stage.");
    end

    // Overflow fires on the step that wraps the top count; clear wins.
    assign overflow = step & ~clear & (count == {WIDTH{1'b1}});

    // Count divider periods.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (step) begin
            count <= count + 1'b1;
        end
    end

endmodule

// [verilog/wdt_divider.sv]
`timescale 1ns/1ps
module wdt_divider #(
    parameter int WIDTH = wdt_pkg::DIV_WIDTH
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             tick,
    input  wire logic             hold,
    input  wire logic [4:0]       exponent,
    output logic                  stage_pulse
);

    // -----------------------------------------------------------------
    // Elaboration check.
    // -----------------------------------------------------------------
    if (WIDTH < int'(wdt_pkg::FAST_DIV_EXP)) begin : g_width_check
        $error("Divider is too narrow for the longest tap.");
    end

    logic [WIDTH-1:0] phase;
    wire  [WIDTH-1:0] tap_mask = ~({WIDTH{1'b1}} << exponent);
    wire              step     = tick & ~hold;
    wire              tap_wrap = step & ((phase & tap_mask) == tap_mask);

    // Free-running phase; a counter clear never touches it.
    // A pulse that meets a hold stays pending, so no counter step is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase       <= '0;
            stage_pulse <= 1'b0;
        end else begin
            phase       <= step ? phase + 1'b1 : phase;
            stage_pulse <= hold ? stage_pulse : tap_wrap; // [R14]
        end
    end

endmodule

// [verilog/wdt_pkg.sv]
package wdt_pkg;

    // -----------------------------------------------------------------
    // Register map, word indices; the byte address is four times each.
    // -----------------------------------------------------------------
    localparam logic [7:0] CONTROL_INDEX = 8'h34;
    localparam logic [7:0] COMMAND_INDEX = 8'h35;
    localparam logic [7:0] STATUS_INDEX  = 8'h36;

    // -----------------------------------------------------------------
    // Control register layout and reset value.
    // -----------------------------------------------------------------
    localparam int         TRAP_AREA_BIT   = 5;
    localparam int         TRAP_ACTION_BIT = 4;
    localparam int         RUN_ENABLE_BIT  = 3;
    localparam int         PERIOD_MSB      = 2;
    localparam int         PERIOD_LSB      = 1;
    localparam int         OVF_ACTION_BIT  = 0;
    localparam logic [7:0] CONTROL_RESET   = 8'h39;

    // -----------------------------------------------------------------
    // Command codes.
    // -----------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR    = 8'h4e;
    localparam logic [7:0] CMD_DISABLE  = 8'hb1;
    localparam logic [7:0] CMD_ARM_TRAP = 8'hd2;

    // -----------------------------------------------------------------
    // Status register layout.
    // -----------------------------------------------------------------
    localparam int ST_ACTIVE_BIT  = 0;
    localparam int ST_OVF_BIT     = 1;
    localparam int ST_COUNT_LSB   = 2;
    localparam int ST_COUNT_MSB   = 3;
    localparam int ST_TRAP_BIT    = 4;
    localparam int ST_HOLD_BIT    = 5;

    // -----------------------------------------------------------------
    // Divider taps: the binary counter adds four divider periods.
    // -----------------------------------------------------------------
    localparam logic [4:0] FAST_DIV_EXP = 5'h17;
    localparam logic [4:0] SLOW_DIV_EXP = 5'h0f;
    localparam int         DIV_WIDTH    = 23;
    localparam int         BIN_WIDTH    = 2;

    // Run state of the watchdog.
    typedef enum logic [1:0] {
        WDT_RUN = 2'b01,
        WDT_OFF = 2'b10
    } run_state_t;

    // Divider tap exponent: two octaves less for each period step.
    function automatic logic [4:0] div_exponent(input logic [1:0] period, input logic use_slow);
        logic [4:0] base;
        base = use_slow ? SLOW_DIV_EXP : FAST_DIV_EXP;
        return base - {2'h0, period, 1'h0};
    endfunction

    // Byte address of a register index.
    function automatic logic [9:0] byte_addr(input logic [7:0] index);
        return {index, 2'h0};
    endfunction

endpackage

// [verilog/wdt_top.sv]
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
// Operation
// R1: Overflow action defaults to reset request.
// R2: Action, once cleared, stays cleared until reset.
// R3: Run enable resets to one; counts immediately.
// R4: Control resets with fields 1,1,1,00,1.
// R5: Overflow with action one requests reset.
// R6: Overflow with action zero requests interrupt.
// R7: Period code and clock select detection time.
// R8: Divider then binary counter; clear spares divider.
// R9: Software clears within three quarters period.
// R10: Decode clear, disable, arm codes; ignore others.
// R11: Disable code works only with enable zero.
// R12: Software stops watchdog in documented order.
// R13: Disabled watchdog holds binary counters cleared.
// R14: Low-power modes pause and resume counting.
// R15: Control register is write-only, reads undefined.
// R16: Watchdog interrupt ignores interrupt master flag.
// R17: New watchdog interrupt serviced at once.
// R18: Software loads stack pointer before interrupt select.
// R19: Software disables or clears before stop mode.
// R20: Software never clears counter inside interrupt task.
// R21: Trap area takes effect after arm code.
// R22: Each overflow gives one single-cycle request.
module wdt_top #(
    parameter int ADDR_WIDTH = 10
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  fast_tick,
    input  wire logic                  slow_tick,
    input  wire logic                  slow_mode,
    input  wire logic                  divider_tap_select,
    input  wire logic                  low_power_hold,
    output logic                       wdt_reset_request,
    output logic                       watchdog_interrupt_request,
    output logic                       trap_area_select,
    output logic                       trap_action_select,
    output logic                       watchdog_active
);

    // -----------------------------------------------------------------
    // Elaboration check.
    // -----------------------------------------------------------------
    if (ADDR_WIDTH < 10) begin : g_addr_check
        $error("Address bus too narrow for the register map.");
    end

    // -----------------------------------------------------------------
    // Bus decode.
    // -----------------------------------------------------------------
    wire [9:0] word_addr   = paddr[9:0];
    wire       high_zero   = (paddr >> 10) == '0;
    wire       hit_control = high_zero & (word_addr == wdt_pkg::byte_addr(wdt_pkg::CONTROL_INDEX));
    wire       hit_command = high_zero & (word_addr == wdt_pkg::byte_addr(wdt_pkg::COMMAND_INDEX));
    wire       hit_status  = high_zero & (word_addr == wdt_pkg::byte_addr(wdt_pkg::STATUS_INDEX));
    wire       mapped      = hit_control | hit_command | hit_status;
    wire       setup_phase = psel & ~penable;
    wire       write_taken = psel & penable & pready & pwrite & ~pslverr;
    wire       ctrl_write  = write_taken & hit_control;
    wire       cmd_write   = write_taken & hit_command;
    wire [7:0] wbyte       = pwdata[7:0];

    // Command decode; any other value has no effect. [R10]
    wire clear_cmd   = cmd_write & (wbyte == wdt_pkg::CMD_CLEAR);
    wire disable_cmd = cmd_write & (wbyte == wdt_pkg::CMD_DISABLE);
    wire arm_cmd     = cmd_write & (wbyte == wdt_pkg::CMD_ARM_TRAP);

    // -----------------------------------------------------------------
    // Control fields.
    // -----------------------------------------------------------------
    logic                  ovf_action;
    logic                  run_enable;
    logic [1:0]            period;
    logic                  trap_area_pending;
    wdt_pkg::run_state_t   run_state;
    wdt_pkg::run_state_t   next_run_state;

    // Disable only from a cleared enable bit; otherwise keep running. [R11] [R12]
    always_comb begin
        next_run_state = run_state;
        case (run_state)
            wdt_pkg::WDT_RUN: begin
                if (disable_cmd && !run_enable) begin
                    next_run_state = wdt_pkg::WDT_OFF;
                end
            end
            wdt_pkg::WDT_OFF: begin
                if (ctrl_write && wbyte[wdt_pkg::RUN_ENABLE_BIT]) begin
                    next_run_state = wdt_pkg::WDT_RUN;
                end
            end
            default: begin
                next_run_state = wdt_pkg::WDT_RUN;
            end
        endcase
    end

    // Control register storage with its reset values. [R1] [R3] [R4]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_action         <= wdt_pkg::CONTROL_RESET[wdt_pkg::OVF_ACTION_BIT];
            run_enable         <= wdt_pkg::CONTROL_RESET[wdt_pkg::RUN_ENABLE_BIT];
            period             <= wdt_pkg::CONTROL_RESET[wdt_pkg::PERIOD_MSB:wdt_pkg::PERIOD_LSB];
            trap_action_select <= wdt_pkg::CONTROL_RESET[wdt_pkg::TRAP_ACTION_BIT];
            trap_area_pending  <= wdt_pkg::CONTROL_RESET[wdt_pkg::TRAP_AREA_BIT];
        end else if (ctrl_write) begin
            ovf_action         <= ovf_action & wbyte[wdt_pkg::OVF_ACTION_BIT]; // [R2]
            run_enable         <= wbyte[wdt_pkg::RUN_ENABLE_BIT];
            period             <= wbyte[wdt_pkg::PERIOD_MSB:wdt_pkg::PERIOD_LSB];
            trap_action_select <= wbyte[wdt_pkg::TRAP_ACTION_BIT];
            trap_area_pending  <= wbyte[wdt_pkg::TRAP_AREA_BIT];
        end
    end

    // Run state and the armed trap area, which moves only on the arm code.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_state        <= wdt_pkg::WDT_RUN;
            watchdog_active  <= 1'b1;
            trap_area_select <= wdt_pkg::CONTROL_RESET[wdt_pkg::TRAP_AREA_BIT];
        end else begin
            run_state        <= next_run_state;
            watchdog_active  <= (next_run_state == wdt_pkg::WDT_RUN);
            trap_area_select <= arm_cmd ? trap_area_pending : trap_area_select; // [R21]
        end
    end

    // -----------------------------------------------------------------
    // Counting chain.
    // -----------------------------------------------------------------
    wire       use_slow = divider_tap_select | slow_mode;
    wire       src_tick = use_slow ? slow_tick : fast_tick;
    wire [4:0] tap_exp  = wdt_pkg::div_exponent(period, use_slow); // [R7]
    wire       running  = (run_state == wdt_pkg::WDT_RUN);
    wire       stage_pulse;
    wire [1:0] bin_count;
    wire       bin_overflow;

    // Divider keeps its phase across a clear; low-power modes freeze it. [R8] [R14]
    wdt_divider #(
        .WIDTH (wdt_pkg::DIV_WIDTH)
    ) u_divider (
        .pclk        (pclk),
        .presetn     (presetn),
        .tick        (src_tick),
        .hold        (low_power_hold),
        .exponent    (tap_exp),
        .stage_pulse (stage_pulse)
    );

    // Binary counter cleared by the clear code and while disabled. [R8] [R13]
    wdt_binary_counter #(
        .WIDTH (wdt_pkg::BIN_WIDTH)
    ) u_binary (
        .pclk     (pclk),
        .presetn  (presetn),
        .step     (stage_pulse & ~low_power_hold),
        .clear    (clear_cmd | ~running),
        .count    (bin_count),
        .overflow (bin_overflow)
    );

    // One-cycle requests; the interrupt has no mask and no pending gate. [R5] [R6] [R16] [R17] [R22]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_request          <= 1'b0;
            watchdog_interrupt_request <= 1'b0;
        end else begin
            wdt_reset_request          <= bin_overflow & ovf_action;
            watchdog_interrupt_request <= bin_overflow & ~ovf_action;
        end
    end

    // -----------------------------------------------------------------
    // Read path and bus answer.
    // -----------------------------------------------------------------
    wire [31:0] status_word = {26'h0, low_power_hold, trap_area_select, bin_count, ovf_action, running};

    // Control and command read as zero; only status shows state. [R15]
    wire [31:0] read_word = hit_status ? status_word : 32'h0;

    // Answer in the first access cycle; unmapped addresses get an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            prdata  <= (setup_phase & ~pwrite) ? read_word : 32'h0;
        end
    end

    // -----------------------------------------------------------------
    // Assertions.
    // -----------------------------------------------------------------
    sequence s_overflow_reset;
        bin_overflow && ovf_action;
    endsequence

    sequence s_overflow_irq;
        bin_overflow && !ovf_action;
    endsequence

    property p_reset_request;
        @(posedge pclk) disable iff (!presetn)
        s_overflow_reset |=> wdt_reset_request && !watchdog_interrupt_request;
    endproperty
    a_reset_request: assert property (p_reset_request) else $error("Reset request missing."); // [R5]

    property p_interrupt_request;
        @(posedge pclk) disable iff (!presetn)
        s_overflow_irq |=> watchdog_interrupt_request && !wdt_reset_request;
    endproperty
    a_interrupt_request: assert property (p_interrupt_request) else $error("Interrupt missing."); // [R6]

    property p_single_pulse;
        @(posedge pclk) disable iff (!presetn)
        (wdt_reset_request || watchdog_interrupt_request) |=> !(wdt_reset_request || watchdog_interrupt_request);
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("Request wider than one cycle."); // [R22]

    property p_action_sticky;
        @(posedge pclk) disable iff (!presetn)
        !ovf_action |=> !ovf_action;
    endproperty
    a_action_sticky: assert property (p_action_sticky) else $error("Overflow action returned to one."); // [R2]

    property p_disable_guard;
        @(posedge pclk) disable iff (!presetn)
        (disable_cmd && run_enable && running) |=> running && watchdog_active;
    endproperty
    a_disable_guard: assert property (p_disable_guard) else $error("Disabled with enable set."); // [R11]

    property p_disabled_cleared;
        @(posedge pclk) disable iff (!presetn)
        (!running ##1 !running) |-> bin_count == 2'h0 && !wdt_reset_request;
    endproperty
    a_disabled_cleared: assert property (p_disabled_cleared) else $error("Counter moved while disabled."); // [R13]

    property p_hold_pause;
        @(posedge pclk) disable iff (!presetn)
        (low_power_hold && running && !clear_cmd) |=> $stable(bin_count);
    endproperty
    a_hold_pause: assert property (p_hold_pause) else $error("Counter moved in low-power hold."); // [R14]

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        clear_cmd |=> bin_count == 2'h0 ##1 !wdt_reset_request && !watchdog_interrupt_request;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear code did not clear the counter."); // [R8]

    property p_trap_arm;
        @(posedge pclk) disable iff (!presetn)
        !arm_cmd |=> $stable(trap_area_select);
    endproperty
    a_trap_arm: assert property (p_trap_arm) else $error("Trap area changed without arm code."); // [R21]

    property p_control_read;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && hit_control) |=> pready && prdata == 32'h0;
    endproperty
    a_control_read: assert property (p_control_read) else $error("Control read returned data."); // [R15]

endmodule
